// ### common/cspf_pkg.sv
// Shared constants, states and bus carriers for the setpoint follower
package cspf_pkg;
    // ==================================================================
    // Timing
    localparam int unsigned CLK_NS = 5;            // 200 MHz system clock
    localparam int unsigned MS_NS  = 1000000;      // One cycle-time unit
    localparam int unsigned MS_CYC = MS_NS / CLK_NS;
    // ==================================================================
    // Mode codes and time index
    localparam logic [7:0] MODE_IP   = 8'h07;
    localparam logic [7:0] MODE_CSP  = 8'h08;
    localparam logic [7:0] TINDEX_MS = 8'hfd;      // Minus three: millisecond base
    // ==================================================================
    // Register byte offsets
    localparam logic [7:0] OFS_MODE   = 8'h00;
    localparam logic [7:0] OFS_CTRL   = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_TGT    = 8'h0c;
    localparam logic [7:0] OFS_PERIOD = 8'h10;
    localparam logic [7:0] OFS_FEWIN  = 8'h14;
    localparam logic [7:0] OFS_FETIME = 8'h18;
    localparam logic [7:0] OFS_LIMLO  = 8'h1c;
    localparam logic [7:0] OFS_LIMHI  = 8'h20;
    localparam logic [7:0] OFS_VPROF  = 8'h24;
    localparam logic [7:0] OFS_VMOTOR = 8'h28;
    localparam logic [7:0] OFS_RAMP   = 8'h2c;
    localparam logic [7:0] OFS_DEMAND = 8'h30;
    localparam logic [7:0] OFS_EVT    = 8'h34;
    // ==================================================================
    // Control and status bit positions
    localparam int CB_OPEN   = 0;   // Power stage in operation enabled
    localparam int CB_CLOSED = 1;   // Closed loop active
    localparam int CB_NMT    = 2;   // Network in operational state
    localparam int CB_BUFEN  = 3;   // Target buffer enable
    localparam int CB_IPEN   = 4;   // Interpolation enable
    localparam int CB_HALT   = 8;   // Halt
    localparam int SB_SYNC   = 8;
    localparam int SB_REACH  = 10;
    localparam int SB_LIMIT  = 11;
    localparam int SB_ACTIVE = 12;
    localparam int SB_FERR   = 13;
    // ==================================================================
    // Reset values and bus answers
    localparam logic [7:0]  PERIOD_RST = 8'h01;
    localparam logic [31:0] FEWIN_RST  = 32'h00000100;
    localparam logic [15:0] FETIME_RST = 16'h000a;
    localparam logic [31:0] LIMLO_RST  = 32'h80000000;
    localparam logic [31:0] LIMHI_RST  = 32'h7fffffff;
    localparam logic [31:0] VPROF_RST  = 32'h00000400;
    localparam logic [31:0] VMOTOR_RST = 32'h00000800;
    localparam logic [15:0] RAMP_RST   = 16'h0040;
    localparam logic [1:0]  RESP_OK    = 2'h0;
    localparam logic [1:0]  RESP_ERR   = 2'h2;
    // ==================================================================
    // Motion states
    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_RUN  = 3'h2,
        ST_HALT = 3'h4
    } cspf_motion_e;
    // ==================================================================
    // Register bus carriers
    typedef struct packed {
        logic [7:0]  awaddr;
        logic        awvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        wvalid;
        logic        bready;
        logic [7:0]  araddr;
        logic        arvalid;
        logic        rready;
    } cspf_axi_req_s;
    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [1:0]  rresp;
        logic [31:0] rdata;
    } cspf_axi_rsp_s;
endpackage : cspf_pkg

// ### verilog/cspf_sync3.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module cspf_sync3 #(
    parameter int W = 1                 // Number of bits
) (
    input  wire logic         clk_sys,  // System clock
    input  wire logic         resetn,   // Async reset, active low
    input  wire logic [W-1:0] d_in,     // Asynchronous input
    output logic      [W-1:0] q_out     // Filtered level
);
    typedef struct packed {
        logic [W-1:0] s1, s2, s3, o;
    } cspf_sync_s;
    cspf_sync_s q, d;

    // Output takes a new level only when stages two and three agree
    always_comb begin
        d    = q;
        d.s1 = d_in;
        d.s2 = q.s1;
        d.s3 = q.s2;
        d.o  = (~(q.s2 ^ q.s3) & q.s3) | ((q.s2 ^ q.s3) & q.o);
    end

    // State register
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign q_out = q.o;
endmodule : cspf_sync3

// ### verilog/cspf_top.sv
// Setpoint follower: register slave, interpolation, sync lock and status
//
// The AXI4-Lite register port and the placing of the registers were decided locally.
`timescale 1ns/1ps
// Behaviour
// - Mode code 7 selects interpolated position mode.
// - Mode code 8 selects cyclic synchronous position mode.
// - Interpolation locks to SYNC once the network is operational.
// - Cyclic position mode also locks its cycle to SYNC.
// - Interpolation enable bit starts interpolation toward targets.
// - Halt ramps speed down to zero; release ramps it up again.
// - Target reached: at target without halt, or speed zero under halt.
// - Active bit shows interpolation running in interpolated mode.
// - Following error flag only in closed loop after timeout.
// - Demand moves linearly from present position to latest target.
// - Only linear interpolation and one pending target exist.
// - Interpolation period is given in milliseconds.
// - Closed loop caps speed at lesser of profile and motor maxima.
// - Motor is driven only in operation enabled state.
// - Cyclic mode follows absolute targets directly, no ramps, no enable bit.
// - Cyclic mode status bit 8 shows bus synchronisation.
// - Cyclic mode status bit 12 shows the target drives control.
// - Cyclic mode status bit 11 flags demand beyond position limits.
// - Error when actual stays outside symmetric band beyond timeout milliseconds.
// - Cycle time is period times ten to index; index fixed at -3.
module cspf_top #(
    parameter int unsigned MS_CYCLES = cspf_pkg::MS_CYC  // Clock cycles per millisecond
) (
    input  wire logic                    clk_sys,     // System clock
    input  wire logic                    resetn,      // Async reset, active low
    input  wire cspf_pkg::cspf_axi_req_s axi_req,     // Register bus request
    output cspf_pkg::cspf_axi_rsp_s      axi_rsp,     // Register bus answer
    input  wire logic                    sync_pin,    // SYNC strobe from bus decoder
    input  wire logic signed [31:0]      pos_actual,  // Encoder position
    output logic signed [31:0]           demand_pos,  // Position demand
    output logic                         drive_en,    // Power stage enable
    output logic [15:0]                  status_word  // Mode status bits
);
    import cspf_pkg::*;

    typedef struct packed {
        logic               awready, wready, bvalid, aw_have, w_have;
        logic [1:0]         bresp, rresp;
        logic [7:0]         waddr;
        logic [31:0]        wdata, rdata;
        logic [3:0]         wstrb;
        logic               arready, rvalid;
        logic [7:0]         mode, period, ms_left;
        logic [15:0]        ctrl, fetime, accel, decel, fe_cnt, status;
        logic signed [31:0] tgt, dem, limlo, limhi;
        logic [31:0]        fewin, vprof, vmotor, vel, ms_cnt;
        cspf_motion_e       st;
        logic [8:0]         sync_wd;
        logic               sync_ok, sync_prev, ferr, evt, drv;
    } cspf_state_s;

    localparam cspf_state_s Q_RST = '{
        awready: 1'b1, wready: 1'b1, arready: 1'b1, period: PERIOD_RST,
        fewin: FEWIN_RST, fetime: FETIME_RST, limlo: LIMLO_RST, limhi: LIMHI_RST,
        vprof: VPROF_RST, vmotor: VMOTOR_RST, accel: RAMP_RST, decel: RAMP_RST,
        st: ST_IDLE, default: '0
    };

    cspf_state_s q, d;
    logic        sync_lvl;
    logic        tick;
    logic        sync_edge;
    logic        wr_go;

    // ==================================================================
    // SYNC strobe arrives from another domain
    cspf_sync3 #(
        .W (1)
    ) u_sync (
        .clk_sys (clk_sys),
        .resetn  (resetn),
        .d_in    (sync_pin),
        .q_out   (sync_lvl)
    );

    // ==================================================================
    // Register read decode: bit 32 flags a mapped offset
    function automatic logic [32:0] rd(input cspf_state_s s, input logic [7:0] a);
        logic [32:0] r;
        r = {1'b1, 32'h0};
        case (a)
            OFS_MODE:   r[31:0] = {24'h0, s.mode};
            OFS_CTRL:   r[31:0] = {16'h0, s.ctrl};
            OFS_STATUS: r[31:0] = {16'h0, s.status};
            OFS_TGT:    r[31:0] = s.tgt;
            OFS_PERIOD: r[31:0] = {16'h0, TINDEX_MS, s.period};
            OFS_FEWIN:  r[31:0] = s.fewin;
            OFS_FETIME: r[31:0] = {16'h0, s.fetime};
            OFS_LIMLO:  r[31:0] = s.limlo;
            OFS_LIMHI:  r[31:0] = s.limhi;
            OFS_VPROF:  r[31:0] = s.vprof;
            OFS_VMOTOR: r[31:0] = s.vmotor;
            OFS_RAMP:   r[31:0] = {s.decel, s.accel};
            OFS_DEMAND: r[31:0] = s.dem;
            OFS_EVT:    r[31:0] = {31'h0, s.evt};
            default:    r = 33'h0;
        endcase
        return r;
    endfunction : rd

    // ==================================================================
    // Cycle base and write strobe
    assign sync_edge = sync_lvl && !q.sync_prev && q.ctrl[CB_NMT];
    assign tick      = (q.ms_cnt == 32'(MS_CYCLES - 1)) || sync_edge;
    assign wr_go     = q.aw_have && q.w_have && !q.bvalid;

    // Next-state logic for bus, motion, supervision and status
    always_comb begin
        logic [32:0]        rv;
        logic [31:0]        wv;
        logic [31:0]        lim_v;
        logic [32:0]        nv;
        logic [32:0]        mag;
        logic signed [32:0] diff, step, vs, nd, err;
        logic               ip, csp, op, halt, run;
        rv    = 33'h0;
        wv    = 32'h0;
        lim_v = 32'h0;
        nv    = 33'h0;
        mag   = 33'h0;
        diff  = '0;
        step  = '0;
        vs    = '0;
        nd    = '0;
        err   = '0;
        d     = q;
        ip    = (q.mode == MODE_IP);
        csp   = (q.mode == MODE_CSP);
        op    = q.ctrl[CB_OPEN];
        halt  = q.ctrl[CB_HALT];
        run   = op && ip && q.ctrl[CB_IPEN];

        // Millisecond prescaler, restarted by SYNC to lock the cycle
        d.ms_cnt    = tick ? 32'h0 : q.ms_cnt + 32'h1;
        d.sync_prev = sync_lvl;
        if (!q.ctrl[CB_NMT] || q.sync_wd > {q.period, 1'b0}) begin
            d.sync_ok = 1'b0;
        end
        if (sync_edge) begin
            d.sync_wd = 9'h0;
            d.sync_ok = 1'b1;
        end else if (tick && q.sync_wd != 9'h1ff) begin
            d.sync_wd = q.sync_wd + 9'h1;
        end

        // Write address and data channels, taken in either order
        if (axi_req.awvalid && q.awready) begin
            d.aw_have = 1'b1;
            d.awready = 1'b0;
            d.waddr   = axi_req.awaddr;
        end
        if (axi_req.wvalid && q.wready) begin
            d.w_have = 1'b1;
            d.wready = 1'b0;
            d.wdata  = axi_req.wdata;
            d.wstrb  = axi_req.wstrb;
        end
        if (q.bvalid && axi_req.bready) begin
            d.bvalid  = 1'b0;
            d.awready = 1'b1;
            d.wready  = 1'b1;
        end

        // Read channel: answer one cycle after the address is taken
        if (axi_req.arvalid && q.arready) begin
            rv        = rd(q, axi_req.araddr);
            d.rdata   = rv[31:0];
            d.rresp   = rv[32] ? RESP_OK : RESP_ERR;
            d.rvalid  = 1'b1;
            d.arready = 1'b0;
        end
        if (q.rvalid && axi_req.rready) begin
            d.rvalid  = 1'b0;
            d.arready = 1'b1;
        end

        // Speed limit depends on the loop type
        lim_v = (q.ctrl[CB_CLOSED] && q.vmotor < q.vprof) ? q.vmotor : q.vprof;

        // Interpolation state machine
        case (q.st)
            ST_IDLE: begin
                if (run) begin
                    d.st = halt ? ST_HALT : ST_RUN;
                end
            end
            ST_RUN: begin
                if (!run) begin
                    d.st = ST_IDLE;
                end else if (halt) begin
                    d.st = ST_HALT;
                end
            end
            ST_HALT: begin
                if (!run) begin
                    d.st = ST_IDLE;
                end else if (!halt) begin
                    d.st = ST_RUN;
                end
            end
            default: d.st = ST_IDLE;
        endcase

        // Speed ramp: brake under halt, start ramp otherwise
        if (q.st == ST_IDLE) begin
            d.vel = 32'h0;
        end else if (tick && q.st == ST_HALT) begin
            d.vel = (q.vel > {16'h0, q.decel}) ? q.vel - {16'h0, q.decel} : 32'h0;
        end else if (tick) begin
            nv    = {1'b0, q.vel} + {17'h0, q.accel};
            d.vel = (nv > {1'b0, lim_v}) ? lim_v : nv[31:0];
        end

        // Linear step toward the single pending target
        if (tick && q.st != ST_IDLE && op) begin
            diff = $signed({q.tgt[31], q.tgt}) - $signed({q.dem[31], q.dem});
            step = (q.ms_left != 8'h0) ? diff / $signed({25'h0, q.ms_left}) : diff;
            vs   = $signed({1'b0, q.vel});
            if (step > vs) begin
                step = vs;
            end else if (step < -vs) begin
                step = -vs;
            end
            nd    = $signed({q.dem[31], q.dem}) + step;
            d.dem = nd[31:0];
            if (q.ms_left != 8'h0) begin
                d.ms_left = q.ms_left - 8'h1;
            end
        end

        // Cyclic mode takes the absolute target without a ramp
        if (tick && op && csp) begin
            d.dem = q.tgt;
        end

        // Register writes with byte strobes
        if (wr_go) begin
            rv = rd(q, q.waddr);
            for (int i = 0; i < 4; i++) begin
                wv[8*i +: 8] = q.wstrb[i] ? q.wdata[8*i +: 8] : rv[8*i +: 8];
            end
            d.bvalid = 1'b1;
            d.bresp  = rv[32] ? RESP_OK : RESP_ERR;
            d.aw_have = 1'b0;
            d.w_have  = 1'b0;
            case (q.waddr)
                OFS_MODE:   d.mode = wv[7:0];
                OFS_CTRL:   d.ctrl = wv[15:0];
                OFS_TGT: begin
                    if (csp || q.ctrl[CB_BUFEN]) begin
                        d.tgt     = wv;
                        d.ms_left = q.period;
                    end
                end
                OFS_PERIOD: d.period = wv[7:0];
                OFS_FEWIN:  d.fewin  = wv;
                OFS_FETIME: d.fetime = wv[15:0];
                OFS_LIMLO:  d.limlo  = wv;
                OFS_LIMHI:  d.limhi  = wv;
                OFS_VPROF:  d.vprof  = wv;
                OFS_VMOTOR: d.vmotor = wv;
                OFS_RAMP: begin
                    d.accel = wv[15:0];
                    d.decel = wv[31:16];
                end
                OFS_EVT:    d.evt    = q.evt & ~wv[0];
                default:    d.evt    = q.evt;
            endcase
        end

        // Following error supervision, counted in milliseconds
        err = $signed({q.dem[31], q.dem}) - $signed({pos_actual[31], pos_actual});
        mag = err[32] ? 33'(-err) : 33'(err);
        if (!q.ctrl[CB_CLOSED] || mag <= {1'b0, q.fewin}) begin
            d.fe_cnt = 16'h0;
            d.ferr   = 1'b0;
        end else if (tick) begin
            if (q.fe_cnt != 16'hffff) begin
                d.fe_cnt = q.fe_cnt + 16'h1;
            end
            if (q.fe_cnt >= q.fetime) begin
                d.ferr = 1'b1;
            end
        end
        if (d.ferr && !q.ferr) begin
            d.evt = 1'b1;
        end

        // Status word and drive enable
        d.drv               = op;
        d.status            = 16'h0;
        d.status[SB_SYNC]   = csp && q.sync_ok;
        d.status[SB_REACH]  = ip && (halt ? (q.vel == 32'h0) : (q.dem == q.tgt));
        d.status[SB_LIMIT]  = csp && (q.dem < q.limlo || q.dem > q.limhi);
        d.status[SB_ACTIVE] = ip ? (q.st != ST_IDLE) : (csp && op);
        d.status[SB_FERR]   = q.ferr;
        if (csp) begin
            d.status[SB_ACTIVE] = op;
        end
    end

    // State register
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            q <= Q_RST;
        end else begin
            q <= d;
        end
    end

    // Outputs straight from the state register
    assign axi_rsp     = '{awready: q.awready, wready: q.wready, bvalid: q.bvalid,
                           bresp: q.bresp, arready: q.arready, rvalid: q.rvalid,
                           rresp: q.rresp, rdata: q.rdata};
    assign demand_pos  = q.dem;
    assign drive_en    = q.drv;
    assign status_word = q.status;

    // ==================================================================
    // Checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    sequence wr_s(logic [7:0] a, logic [7:0] v);
        wr_go && q.waddr == a && q.wstrb[0] && q.wdata[7:0] == v;
    endsequence

    mode_ip_a: assert property (
        wr_s(OFS_MODE, MODE_IP) |=> q.mode == MODE_IP ##1 !q.aw_have)
        else $error("mode 7 not taken");
    mode_csp_a: assert property (
        wr_s(OFS_MODE, MODE_CSP) |=> q.mode == MODE_CSP)
        else $error("mode 8 not taken");
    sync_lock_a: assert property (
        sync_edge |=> q.ms_cnt == 32'h0 && q.sync_ok)
        else $error("cycle not locked to sync");
    sync_bit_a: assert property (
        sync_edge && csp_now() && !wr_go |=> ##1 q.status[SB_SYNC])
        else $error("sync status missing");
    drive_off_a: assert property (
        !q.ctrl[CB_OPEN] && !wr_go ##1 !q.ctrl[CB_OPEN] |=> !drive_en && $stable(q.dem))
        else $error("motor driven while not enabled");
    csp_follow_a: assert property (
        tick && q.ctrl[CB_OPEN] && csp_now() |=> q.dem == $past(q.tgt))
        else $error("cyclic target not followed");
    speed_cap_a: assert property (
        tick && q.ctrl[CB_CLOSED] && q.st == ST_RUN && !wr_go |=>
        q.vel <= q.vmotor && q.vel <= q.vprof)
        else $error("speed above limit");
    halt_brake_a: assert property (
        tick && q.st == ST_HALT |=> q.vel <= $past(q.vel))
        else $error("speed rises under halt");
    ferr_time_a: assert property (
        $rose(q.ferr) |-> $past(q.fe_cnt) >= q.fetime && q.ctrl[CB_CLOSED])
        else $error("following error before timeout");
    ferr_evt_a: assert property (
        $rose(q.ferr) |-> q.evt ##1 q.evt)
        else $error("event flag not set");
    ip_active_a: assert property (
        q.st != ST_IDLE && q.mode == MODE_IP && !wr_go |=> q.status[SB_ACTIVE])
        else $error("active bit missing");
    limit_a: assert property (
        csp_now() && q.dem > q.limhi && !wr_go |=> q.status[SB_LIMIT])
        else $error("limit bit missing");

    function automatic logic csp_now();
        return q.mode == MODE_CSP;
    endfunction : csp_now
endmodule : cspf_top

// ### dv/cspf_host_model.sv
// Host-side SYNC source that stands in for the higher-level motion controller
`timescale 1ns/1ps
module cspf_host_model #(
    parameter int unsigned MS_CYCLES = 20,  // Clock cycles per millisecond
    parameter int unsigned PERIOD_MS = 1    // SYNC interval in milliseconds
) (
    input  wire logic clk_sys,   // System clock
    input  wire logic resetn,    // Async reset, active low
    input  wire logic sync_on,   // Network operational, SYNC wanted
    output logic      sync_pin   // SYNC strobe
);
    int unsigned cnt_q;
    // ==================================================================
    // Regular strobe, four clocks high so the input filter keeps it
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            cnt_q    <= 0;
            sync_pin <= 1'b0;
        end else if (!sync_on) begin
            cnt_q    <= 0;
            sync_pin <= 1'b0;
        end else begin
            cnt_q    <= (cnt_q + 1 >= PERIOD_MS * MS_CYCLES) ? 0 : cnt_q + 1;
            sync_pin <= (cnt_q < 4);
        end
    end
endmodule : cspf_host_model

// ### dv/testbench.sv
// Self-checking bench for the setpoint follower
`timescale 1ns/1ps
module testbench;
    import cspf_pkg::*;
    localparam int unsigned MSC = 20;
    logic               clk_sys     = 1'b0;
    logic               resetn      = 1'b0;
    cspf_axi_req_s      req         = '0;
    cspf_axi_rsp_s      rsp;
    logic               sync_on     = 1'b0;
    logic               sync_pin;
    logic signed [31:0] pos_actual  = '0;
    logic signed [31:0] demand_pos;
    logic               drive_en;
    logic [15:0]        status_word;
    logic [31:0]        rd_d;
    logic [1:0]         rd_r;
    logic signed [31:0] t;
    logic signed [31:0] p;
    int                 n_fail      = 0;
    int                 num_checks  = 0;
    // Clock
    always #2.5 clk_sys = ~clk_sys;
    cspf_top #(.MS_CYCLES(MSC)) dut_u (.clk_sys(clk_sys), .resetn(resetn), .axi_req(req),
        .axi_rsp(rsp), .sync_pin(sync_pin), .pos_actual(pos_actual),
        .demand_pos(demand_pos), .drive_en(drive_en), .status_word(status_word));
    cspf_host_model #(.MS_CYCLES(MSC)) host_u (.clk_sys(clk_sys), .resetn(resetn),
        .sync_on(sync_on), .sync_pin(sync_pin));
    // ==================================================================
    // Report and compare helpers
    task automatic test_done;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : test_done
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            $display("wrong value %s exp %h got %h", nm, e, g);
            n_fail++;
        end
    endtask : chk
    task automatic tmo(input int n);
        if (n >= 4000) begin
            $display("wrong value wait exp done got timeout");
            n_fail++;
            test_done();
        end
    endtask : tmo
    function automatic logic lim_exp(input logic signed [31:0] d, lo, hi);
        return (d < lo) || (d > hi);
    endfunction : lim_exp
    // ==================================================================
    // Register bus master
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_sys);
        req.awaddr  <= a;
        req.wdata   <= d;
        req.wstrb   <= 4'hf;
        req.awvalid <= 1'b1;
        req.wvalid  <= 1'b1;
        req.bready  <= 1'b1;
        for (n = 0; n < 4000; n++) begin
            @(posedge clk_sys);
            if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
            if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
            if (rsp.bvalid) break;
        end
        req.bready <= 1'b0;
        tmo(n);
    endtask : wr
    task automatic rd(input logic [7:0] a);
        int n;
        @(posedge clk_sys);
        req.araddr  <= a;
        req.arvalid <= 1'b1;
        req.rready  <= 1'b1;
        for (n = 0; n < 4000; n++) begin
            @(posedge clk_sys);
            if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
            if (rsp.rvalid) break;
        end
        rd_d = rsp.rdata;
        rd_r = rsp.rresp;
        req.rready <= 1'b0;
        tmo(n);
    endtask : rd
    task automatic wait_st(input int b, input logic v);
        int n;
        for (n = 0; n < 4000 && status_word[b] !== v; n++) @(posedge clk_sys);
        tmo(n);
    endtask : wait_st
    task automatic wait_dem(input logic [31:0] e);
        int n;
        for (n = 0; n < 4000 && demand_pos !== e; n++) @(posedge clk_sys);
        chk("demand", e, demand_pos);
    endtask : wait_dem
    // ==================================================================
    // Main sequence
    initial begin
        void'($urandom(67849));
        repeat (2) @(posedge clk_sys);
        resetn <= 1'b1;
        rd(OFS_PERIOD);
        chk("period", {16'h0, TINDEX_MS, PERIOD_RST}, rd_d);
        rd(8'h3c);
        chk("resp", {30'h0, RESP_ERR}, {30'h0, rd_r});
        wr(OFS_MODE, {24'h0, MODE_CSP});
        wr(OFS_LIMHI, 32'h0);
        wr(OFS_CTRL, 32'h5);
        sync_on <= 1'b1;
        repeat (6) begin
            t = $urandom();
            wr(OFS_TGT, t);
            wr(OFS_TGT, t);
            repeat (3 * MSC) @(posedge clk_sys);
            chk("demand", t, demand_pos);
            chk("limit", {31'h0, lim_exp(t, LIMLO_RST, 0)}, {31'h0, status_word[SB_LIMIT]});
        end
        chk("follow", 32'h1, {31'h0, status_word[SB_ACTIVE]});
        chk("drive", 32'h1, {31'h0, drive_en});
        wait_st(SB_SYNC, 1'b1);
        chk("sync", 32'h1, {31'h0, status_word[SB_SYNC]});
        sync_on <= 1'b0;
        wait_st(SB_SYNC, 1'b0);
        // Following error in closed loop
        wr(OFS_FETIME, 32'h2);
        wr(OFS_CTRL, 32'h7);
        pos_actual <= demand_pos + 32'h200;
        wait_st(SB_FERR, 1'b1);
        rd(OFS_EVT);
        chk("event", 32'h1, rd_d);
        pos_actual <= demand_pos;
        wait_st(SB_FERR, 1'b0);
        wr(OFS_EVT, 32'h1);
        rd(OFS_EVT);
        chk("event", 32'h0, rd_d);
        // Interpolated mode
        wr(OFS_MODE, {24'h0, MODE_IP});
        rd(OFS_MODE);
        chk("mode", {24'h0, MODE_IP}, rd_d);
        p = t;
        t = demand_pos + 32'h300;
        wr(OFS_CTRL, 32'h5);
        wr(OFS_TGT, t);
        rd(OFS_TGT);
        chk("target", p, rd_d);
        wr(OFS_PERIOD, 32'h4);
        wr(OFS_CTRL, 32'h1f);
        wr(OFS_TGT, t);
        wait_st(SB_ACTIVE, 1'b1);
        wait_dem(t);
        wait_st(SB_REACH, 1'b1);
        t = t + 32'h4000;
        wr(OFS_TGT, t);
        wr(OFS_CTRL, 32'h11f);
        wait_st(SB_REACH, 1'b1);
        p = demand_pos;
        repeat (2 * MSC) @(posedge clk_sys);
        chk("halted", p, demand_pos);
        wr(OFS_CTRL, 32'h1f);
        wait_dem(t);
        wr(OFS_CTRL, 32'h0);
        repeat (2) @(posedge clk_sys);
        chk("drive", 32'h0, {31'h0, drive_en});
        test_done();
    end
endmodule : testbench
